// >>> verilog/tmr_pkg.sv
// Purpose: Shared constants for the 16-bit timer control block.
// Assumes: Byte-wide register port at the printed addresses.
// Notes:   Mode enum order matches the two upper mode bits.
package tmr_pkg;

	// ------------------------------------------------------------------
	// Register addresses.
	// ------------------------------------------------------------------
	localparam logic [15:0] TMR_ADDR_MODE_CTRL   = 16'hFF60;
	localparam logic [15:0] TMR_ADDR_CAPCMP_CTRL = 16'hFF62;
	localparam logic [15:0] TMR_ADDR_OUT_CTRL    = 16'hFF63;
	localparam logic [15:0] TMR_ADDR_COUNT_LO    = 16'hFF12;
	localparam logic [15:0] TMR_ADDR_COUNT_HI    = 16'hFF13;
	localparam logic [15:0] TMR_ADDR_FIRST_LO    = 16'hFF14;
	localparam logic [15:0] TMR_ADDR_FIRST_HI    = 16'hFF15;
	localparam logic [15:0] TMR_ADDR_SECOND_LO   = 16'hFF16;
	localparam logic [15:0] TMR_ADDR_SECOND_HI   = 16'hFF17;

	// ------------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------------
	localparam int TMR_BIT_OVF      = 0;
	localparam int TMR_BIT_MODE_LO  = 1;
	localparam int TMR_BIT_MODE_HI  = 3;
	localparam int TMR_BIT_FIRST_CAP  = 0;
	localparam int TMR_BIT_FIRST_TRIG = 1;
	localparam int TMR_BIT_SECOND_CAP = 2;
	localparam int TMR_BIT_OUT_EN   = 0;
	localparam int TMR_BIT_INV_FIRST  = 1;
	localparam int TMR_BIT_LVL_RESET  = 2;
	localparam int TMR_BIT_LVL_SET    = 3;
	localparam int TMR_BIT_INV_SECOND = 4;
	localparam int TMR_BIT_OS_EN    = 5;
	localparam int TMR_BIT_OS_TRIG  = 6;

	// ------------------------------------------------------------------
	// Reset values and fixed codes.
	// ------------------------------------------------------------------
	localparam logic [7:0]  TMR_RESET_BYTE  = 8'h00;
	localparam logic [15:0] TMR_COUNT_ZERO  = 16'h0000;
	localparam logic [15:0] TMR_COUNT_ONE   = 16'h0001;
	localparam logic [15:0] TMR_COUNT_MAX   = 16'hFFFF;
	localparam logic [1:0]  TMR_EDGE_FALL   = 2'h0;
	localparam logic [1:0]  TMR_EDGE_RISE   = 2'h1;
	localparam logic [1:0]  TMR_EDGE_BOTH   = 2'h3;

	typedef enum logic [1:0] {
		TMR_STOP,
		TMR_FREE,
		TMR_CLR_EDGE,
		TMR_CLR_MATCH
	} tmr_mode_type;

endpackage

// >>> verilog/tmr_edge_detect.sv
// Purpose: Noise-filtered valid-edge detector for one timer input pin.
// Assumes: pin_in is synchronous to mclk; sample marks one count clock.
// Notes:   A level must be seen on two count clocks before it counts.
`timescale 1ns/1ps
module tmr_edge_detect
	import tmr_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       sample,
	input  wire logic       run,
	input  wire logic       pin_in,
	input  wire logic [1:0] edge_sel,
	output logic            valid_pulse,
	output logic            opposite_pulse
);
	logic [1:0] hist_q, hist_d;
	logic       level_q, level_d;
	logic       rise, fall;

	// Level is only followed while running, so a level change made while
	// stopped shows as an edge right after the timer starts again.
	always_comb begin
		hist_d  = hist_q;
		level_d = level_q;
		rise    = 1'b0;
		fall    = 1'b0;
		if (sample && run) begin
			hist_d = {hist_q[0], pin_in};
			if (hist_q[1] == hist_q[0] && hist_q[0] != level_q) begin
				level_d = hist_q[0];
				rise    = hist_q[0];
				fall    = !hist_q[0];
			end
		end
		unique case (edge_sel)
			TMR_EDGE_FALL: begin
				valid_pulse    = fall;
				opposite_pulse = rise;
			end
			TMR_EDGE_RISE: begin
				valid_pulse    = rise;
				opposite_pulse = fall;
			end
			TMR_EDGE_BOTH: begin
				valid_pulse    = rise | fall;
				opposite_pulse = 1'b0;
			end
			default: begin
				valid_pulse    = 1'b0;
				opposite_pulse = 1'b0;
			end
		endcase
	end

	// History and filtered level.
	always_ff @(posedge mclk) begin
		if (rst) begin
			hist_q  <= 2'h0;
			level_q <= 1'b0;
		end else begin
			hist_q  <= hist_d;
			level_q <= level_d;
		end
	end

endmodule

// >>> verilog/tmr_core.sv
// Purpose: Mode, capture/compare and output control of a 16-bit timer.
// Assumes: count_tick is a one-cycle pulse per selected count clock.
// Notes:   Registers are bytes reached by address, one write per cycle.
//
// Summary of operation
// (RQ1) Mode field: stop, free-running, clear on first input edge, clear on first match.
// (RQ2) Stopped: counter zero, output unchanged, no counts or interrupts from edges.
// (RQ3) Matches invert the output; low mode bit adds first-input valid edge.
// (RQ4) Compare mode interrupts on match; capture mode interrupts on input edges.
// (RQ5) Overflow flag sets when first register is FFFF and counter wraps.
// (RQ6) Clearing overflow before counter reaches 0001 has no effect.
// (RQ7) Capture latches on one count clock, interrupt follows on the next.
// (RQ8) Software stops the timer before changing mode bits.
// (RQ9) Software stops the timer before low-power modes halting the clock.
// (RQ10) Second register bit selects compare (0) or capture (1).
// (RQ11) First register bit selects compare (0) or capture (1).
// (RQ12) Trigger select: 0 second input edge, 1 first input opposite edge.
// (RQ13) Trigger select 1 with both edges valid: no capture into first.
// (RQ14) Software never sets first register to capture in clear-on-match mode.
// (RQ15) Software stops the timer before writing capture/compare control.
// (RQ16) Capture trigger pulses last longer than two count clocks.
// (RQ17) Writing 1 to software trigger starts a one-shot pulse.
// (RQ18) One-shot enable 0 gives successive pulses, 1 gives one-shot.
// (RQ19) Separate enables gate toggling on first and second matches.
// (RQ20) Level field: 00 no change, 01 reset, 10 set, 11 ignored.
// (RQ21) Output enable 0 holds the pin low, 1 shows the flip-flop.
// (RQ22) One-shot works in free-running and clear-on-edge modes only.
// (RQ23) Counter runs while upper mode bits are nonzero, stops at zero.
// (RQ24) Software trigger bit self-clears and always reads zero.
// (RQ25) Running counter increments per count clock, wrapping to zero.
// (RQ26) Reset clears all control registers: stopped, compare, output low.
`timescale 1ns/1ps
module tmr_core
	import tmr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        count_tick,
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        first_edge_input,
	input  wire logic        second_edge_input,
	input  wire logic [1:0]  first_edge_sel,
	input  wire logic [1:0]  second_edge_sel,
	output logic             timer_output_pin,
	output logic             timer_match_interrupt_first,
	output logic             timer_match_interrupt_second
);
	// ------------------------------------------------------------------
	// State.
	// ------------------------------------------------------------------
	logic [15:0] timer_counter_q, timer_counter_d;
	logic [15:0] first_capture_compare_q, first_capture_compare_d;
	logic [15:0] second_capture_compare_q, second_capture_compare_d;
	logic [2:0]  mode_q, mode_d;
	logic        overflow_flag_q, overflow_flag_d;
	logic        ovf_recent_q, ovf_recent_d;
	logic [2:0]  capcmp_q, capcmp_d;
	logic        oneshot_enable_q, oneshot_enable_d;
	logic        invert_on_second_match_q, invert_on_second_match_d;
	logic        invert_on_first_match_q, invert_on_first_match_d;
	logic        timer_output_enable_q, timer_output_enable_d;
	logic        out_ff_q, out_ff_d;
	logic        armed_q, armed_d;
	logic        cap_pend_first_q, cap_pend_first_d;
	logic        cap_pend_second_q, cap_pend_second_d;
	logic        pin_q, pin_d;
	logic        irq_first_q, irq_first_d;
	logic        irq_second_q, irq_second_d;
	logic [7:0]  rdata_q, rdata_d;

	// ------------------------------------------------------------------
	// Decoded events.
	// ------------------------------------------------------------------
	tmr_mode_type mode;
	logic         run;
	logic         first_valid, first_opposite, second_valid;
	logic         match_first, match_second;
	logic         cap_first, cap_second;
	logic         clear_edge, clear_match, ovf_evt;
	logic         wr_mode, wr_capcmp, wr_out;
	logic         sw_trigger, os_trigger, os_allowed, toggle;

	// Both edge detectors share one filter design; each gets its own pin.
	tmr_edge_detect u_first_edge (
		.mclk           (mclk),
		.rst            (rst),
		.sample         (count_tick),
		.run            (run),
		.pin_in         (first_edge_input),
		.edge_sel       (first_edge_sel),
		.valid_pulse    (first_valid),
		.opposite_pulse (first_opposite)
	);

	tmr_edge_detect u_second_edge (
		.mclk           (mclk),
		.rst            (rst),
		.sample         (count_tick),
		.run            (run),
		.pin_in         (second_edge_input),
		.edge_sel       (second_edge_sel),
		.valid_pulse    (second_valid),
		.opposite_pulse ()  // No opposite-edge capture path on this input.
	);

	// Mode decode and match, capture and clear conditions.
	always_comb begin
		mode         = tmr_mode_type'(mode_q[2:1]);              // [RQ1]
		run          = (mode != TMR_STOP);                       // [RQ23]
		wr_mode      = reg_wr && reg_addr == TMR_ADDR_MODE_CTRL;
		wr_capcmp    = reg_wr && reg_addr == TMR_ADDR_CAPCMP_CTRL;
		wr_out       = reg_wr && reg_addr == TMR_ADDR_OUT_CTRL;
		match_first  = run && count_tick && timer_counter_q == first_capture_compare_q;
		match_second = run && count_tick && timer_counter_q == second_capture_compare_q;
		// First register capture trigger follows the trigger select bit.
		cap_first    = capcmp_q[TMR_BIT_FIRST_CAP] &&                           // [RQ11]
		               (capcmp_q[TMR_BIT_FIRST_TRIG] ? first_opposite : second_valid); // [RQ12] [RQ13]
		cap_second   = capcmp_q[TMR_BIT_SECOND_CAP] && first_valid;             // [RQ10]
		clear_edge   = mode == TMR_CLR_EDGE && first_valid;
		clear_match  = mode == TMR_CLR_MATCH && match_first;
		ovf_evt      = run && count_tick && !clear_edge &&                      // [RQ5]
		               first_capture_compare_q == TMR_COUNT_MAX &&
		               timer_counter_q == TMR_COUNT_MAX;
		sw_trigger   = wr_out && reg_wdata[TMR_BIT_OS_TRIG];                    // [RQ17]
		os_allowed   = mode == TMR_FREE || mode == TMR_CLR_EDGE;                // [RQ22]
		os_trigger   = sw_trigger || (mode == TMR_CLR_EDGE && first_valid);
		toggle       = (match_first && invert_on_first_match_q) ||              // [RQ19]
		               (match_second && invert_on_second_match_q) ||
		               (mode_q[0] && first_valid);                              // [RQ3]
	end

	// ------------------------------------------------------------------
	// Counter and overflow.
	// ------------------------------------------------------------------
	// A stopped counter is held at zero; clears win over the increment.
	always_comb begin
		timer_counter_d = timer_counter_q;
		if (!run) begin
			timer_counter_d = TMR_COUNT_ZERO;                                    // [RQ2]
		end else if (count_tick) begin
			if (clear_edge || clear_match) begin
				timer_counter_d = TMR_COUNT_ZERO;                                // [RQ1]
			end else begin
				timer_counter_d = timer_counter_q + TMR_COUNT_ONE;               // [RQ25]
			end
		end
		// The flag stays sticky until the counter has moved past zero, so a
		// clear too soon after the wrap is overruled.
		ovf_recent_d = ovf_recent_q;
		if (ovf_evt) begin
			ovf_recent_d = 1'b1;
		end else if (count_tick || !run) begin
			ovf_recent_d = 1'b0;
		end
		overflow_flag_d = overflow_flag_q;
		if (wr_mode) begin
			overflow_flag_d = reg_wdata[TMR_BIT_OVF] || ovf_recent_q;            // [RQ6]
		end
		if (ovf_evt) begin
			overflow_flag_d = 1'b1;                                              // [RQ5]
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_counter_q <= TMR_COUNT_ZERO;
			overflow_flag_q <= 1'b0;
			ovf_recent_q    <= 1'b0;
		end else begin
			timer_counter_q <= timer_counter_d;
			overflow_flag_q <= overflow_flag_d;
			ovf_recent_q    <= ovf_recent_d;
		end
	end

	// ------------------------------------------------------------------
	// Control registers, capture/compare registers and interrupts.
	// ------------------------------------------------------------------
	always_comb begin
		mode_d                   = mode_q;
		capcmp_d                 = capcmp_q;
		oneshot_enable_d         = oneshot_enable_q;
		invert_on_second_match_d = invert_on_second_match_q;
		invert_on_first_match_d  = invert_on_first_match_q;
		timer_output_enable_d    = timer_output_enable_q;
		first_capture_compare_d  = first_capture_compare_q;
		second_capture_compare_d = second_capture_compare_q;
		if (wr_mode) begin
			mode_d = reg_wdata[TMR_BIT_MODE_HI:TMR_BIT_MODE_LO];
		end
		if (wr_capcmp) begin
			capcmp_d = reg_wdata[TMR_BIT_SECOND_CAP:TMR_BIT_FIRST_CAP];
		end
		if (wr_out) begin
			oneshot_enable_d         = reg_wdata[TMR_BIT_OS_EN];                 // [RQ18]
			invert_on_second_match_d = reg_wdata[TMR_BIT_INV_SECOND];
			invert_on_first_match_d  = reg_wdata[TMR_BIT_INV_FIRST];
			timer_output_enable_d    = reg_wdata[TMR_BIT_OUT_EN];
		end
		unique case (reg_addr)
			TMR_ADDR_FIRST_LO:  if (reg_wr) first_capture_compare_d[7:0]   = reg_wdata;
			TMR_ADDR_FIRST_HI:  if (reg_wr) first_capture_compare_d[15:8]  = reg_wdata;
			TMR_ADDR_SECOND_LO: if (reg_wr) second_capture_compare_d[7:0]  = reg_wdata;
			TMR_ADDR_SECOND_HI: if (reg_wr) second_capture_compare_d[15:8] = reg_wdata;
			default: begin
			end
		endcase
		// A capture overrides a software write in the same cycle.
		if (cap_first) begin
			first_capture_compare_d = timer_counter_q;                           // [RQ7]
		end
		if (cap_second) begin
			second_capture_compare_d = timer_counter_q;                          // [RQ7]
		end
		// Capture interrupts wait one count clock; compare ones are immediate.
		cap_pend_first_d  = cap_first || (cap_pend_first_q && !count_tick);
		cap_pend_second_d = cap_second || (cap_pend_second_q && !count_tick);
		irq_first_d  = (run && count_tick && cap_pend_first_q) ||                // [RQ7]
		               (match_first && !capcmp_q[TMR_BIT_FIRST_CAP]);            // [RQ4]
		irq_second_d = (run && count_tick && cap_pend_second_q) ||
		               (match_second && !capcmp_q[TMR_BIT_SECOND_CAP]);          // [RQ4]
		if (!run) begin
			cap_pend_first_d  = 1'b0;                                            // [RQ2]
			cap_pend_second_d = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_q                   <= 3'h0;                                   // [RQ26]
			capcmp_q                 <= 3'h0;
			oneshot_enable_q         <= 1'b0;
			invert_on_second_match_q <= 1'b0;
			invert_on_first_match_q  <= 1'b0;
			timer_output_enable_q    <= 1'b0;
			first_capture_compare_q  <= TMR_COUNT_ZERO;
			second_capture_compare_q <= TMR_COUNT_ZERO;
			cap_pend_first_q         <= 1'b0;
			cap_pend_second_q        <= 1'b0;
			irq_first_q              <= 1'b0;
			irq_second_q             <= 1'b0;
		end else begin
			mode_q                   <= mode_d;
			capcmp_q                 <= capcmp_d;
			oneshot_enable_q         <= oneshot_enable_d;
			invert_on_second_match_q <= invert_on_second_match_d;
			invert_on_first_match_q  <= invert_on_first_match_d;
			timer_output_enable_q    <= timer_output_enable_d;
			first_capture_compare_q  <= first_capture_compare_d;
			second_capture_compare_q <= second_capture_compare_d;
			cap_pend_first_q         <= cap_pend_first_d;
			cap_pend_second_q        <= cap_pend_second_d;
			irq_first_q              <= irq_first_d;
			irq_second_q             <= irq_second_d;
		end
	end

	// ------------------------------------------------------------------
	// Output flip-flop, one-shot and read data.
	// ------------------------------------------------------------------
	// One-shot: armed by a trigger, set on second match, reset on first.
	always_comb begin
		out_ff_d = out_ff_q;
		armed_d  = armed_q;
		if (oneshot_enable_q && os_allowed) begin
			if (os_trigger) begin
				armed_d = 1'b1;                                                  // [RQ17]
			end else if (armed_q && match_first) begin
				out_ff_d = 1'b0;                                                 // [RQ18]
				armed_d  = 1'b0;
			end else if (armed_q && match_second) begin
				out_ff_d = 1'b1;
			end
		end else if (!oneshot_enable_q && toggle) begin
			out_ff_d = !out_ff_q;                                                // [RQ3]
		end
		if (!oneshot_enable_q || !run) begin
			armed_d = 1'b0;
		end
		if (wr_out) begin
			unique case ({reg_wdata[TMR_BIT_LVL_SET], reg_wdata[TMR_BIT_LVL_RESET]})
				2'h1: out_ff_d = 1'b0;                                           // [RQ20]
				2'h2: out_ff_d = 1'b1;                                           // [RQ20]
				default: begin
				end
			endcase
		end
		pin_d = timer_output_enable_d && out_ff_d;                               // [RQ21]
		rdata_d = TMR_RESET_BYTE;
		if (reg_rd) begin
			unique case (reg_addr)
				TMR_ADDR_MODE_CTRL:   rdata_d = {4'h0, mode_q, overflow_flag_q};
				TMR_ADDR_CAPCMP_CTRL: rdata_d = {5'h00, capcmp_q};
				TMR_ADDR_OUT_CTRL:    rdata_d = {2'h0, oneshot_enable_q,          // [RQ24]
				                                 invert_on_second_match_q, 2'h0,
				                                 invert_on_first_match_q,
				                                 timer_output_enable_q};
				TMR_ADDR_COUNT_LO:    rdata_d = timer_counter_q[7:0];
				TMR_ADDR_COUNT_HI:    rdata_d = timer_counter_q[15:8];
				TMR_ADDR_FIRST_LO:    rdata_d = first_capture_compare_q[7:0];
				TMR_ADDR_FIRST_HI:    rdata_d = first_capture_compare_q[15:8];
				TMR_ADDR_SECOND_LO:   rdata_d = second_capture_compare_q[7:0];
				TMR_ADDR_SECOND_HI:   rdata_d = second_capture_compare_q[15:8];
				default:              rdata_d = TMR_RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			out_ff_q <= 1'b0;
			armed_q  <= 1'b0;
			pin_q    <= 1'b0;
			rdata_q  <= TMR_RESET_BYTE;
		end else begin
			out_ff_q <= out_ff_d;
			armed_q  <= armed_d;
			pin_q    <= pin_d;
			rdata_q  <= rdata_d;
		end
	end

	assign timer_output_pin             = pin_q;
	assign timer_match_interrupt_first  = irq_first_q;
	assign timer_match_interrupt_second = irq_second_q;
	assign reg_rdata                    = rdata_q;

	// ------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Named steps: a level write to output control, and a capture followed
	// by the next count clock, which must release the capture interrupt.
	sequence s_out_write(logic [1:0] lvl);
		wr_out && reg_wdata[TMR_BIT_LVL_SET:TMR_BIT_LVL_RESET] == lvl;
	endsequence
	sequence s_capture_then_tick;
		cap_first ##1 (count_tick && run);
	endsequence

	// Counter, overflow, capture and output checks.
	property p_stop_zero;
		!run && !wr_mode |=> timer_counter_q == TMR_COUNT_ZERO && !irq_first_q;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("stopped counter not zero"); // [RQ2]
	property p_count_inc;
		count_tick && mode == TMR_FREE && !wr_mode
		|=> timer_counter_q == $past(timer_counter_q) + TMR_COUNT_ONE;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("counter did not step"); // [RQ25]
	property p_clear_match;
		clear_match |=> timer_counter_q == TMR_COUNT_ZERO;
	endproperty
	a_clear_match: assert property (p_clear_match) else $error("no clear on match"); // [RQ1]
	property p_ovf_set;
		ovf_evt |=> overflow_flag_q ##1 (overflow_flag_q || ovf_recent_q == 1'b0);
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missed"); // [RQ5]
	property p_ovf_reset;
		ovf_recent_q && wr_mode && !reg_wdata[TMR_BIT_OVF] |=> overflow_flag_q;
	endproperty
	a_ovf_reset: assert property (p_ovf_reset) else $error("early clear took effect"); // [RQ6]
	property p_capture_latch;
		cap_first |=> first_capture_compare_q == $past(timer_counter_q);
	endproperty
	a_capture_latch: assert property (p_capture_latch) else $error("capture lost"); // [RQ7]
	property p_capture_irq;
		s_capture_then_tick |=> irq_first_q;
	endproperty
	a_capture_irq: assert property (p_capture_irq) else $error("capture irq missing"); // [RQ7]
	property p_no_cap_both;
		capcmp_q[TMR_BIT_FIRST_TRIG] && first_edge_sel == TMR_EDGE_BOTH |-> !cap_first;
	endproperty
	a_no_cap_both: assert property (p_no_cap_both) else $error("capture on both edges"); // [RQ13]
	property p_level_reset;
		s_out_write(2'h1) |=> !out_ff_q;
	endproperty
	a_level_reset: assert property (p_level_reset) else $error("level reset failed"); // [RQ20]
	property p_level_set;
		s_out_write(2'h2) |=> out_ff_q ##0 (pin_q == timer_output_enable_q);
	endproperty
	a_level_set: assert property (p_level_set) else $error("level set failed"); // [RQ20]
	property p_pin_gate;
		pin_q == (timer_output_enable_q && out_ff_q);
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin not gated"); // [RQ21]
	property p_trig_reads_zero;
		reg_rd && reg_addr == TMR_ADDR_OUT_CTRL |=> !reg_rdata[TMR_BIT_OS_TRIG];
	endproperty
	a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger read 1"); // [RQ24]
	property p_no_oneshot_match;
		mode == TMR_CLR_MATCH |-> !(oneshot_enable_q && armed_d && !armed_q);
	endproperty
	a_no_oneshot_match: assert property (p_no_oneshot_match) else $error("one-shot armed"); // [RQ22]

endmodule

// >>> dv/tmr_pins_model.sv
// Purpose: Far-side model of the two edge input pins.
// Assumes: go is a one-cycle request per pin, driven off the clock edge.
// Notes:   Pulses last four ticks so the two-sample filter always passes them.
`timescale 1ns/1ps
module tmr_pins_model (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [1:0] go,
	output logic      [1:0] pins
);
	logic [2:0] left_q [2];
	// A request reloads the hold count; a short pulse would be filtered away.
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 2; i++) begin
			if (rst) begin
				left_q[i] <= 3'h0;
			end else if (go[i]) begin
				left_q[i] <= 3'h4;
			end else if (left_q[i] != 3'h0) begin
				left_q[i] <= left_q[i] - 3'h1;
			end
		end
	end
	assign pins = {left_q[1] != 3'h0, left_q[0] != 3'h0};
endmodule

// >>> dv/tmr_core_tb_top.sv
// Purpose: Self-checking bench for the timer control core.
// Assumes: One count tick per mclk while ticking.
// Notes:   Read results are matched in order against a queue of notes.
`timescale 1ns/1ps
module tmr_core_tb_top;
	import tmr_pkg::*;
	logic        mclk = 0, rst = 1, tick = 0, wr = 0, rd = 0, rd_d = 0;
	logic [15:0] addr = 0;
	logic [7:0]  wd = 0, rdat, v;
	logic [1:0]  go = 0, s1 = 0, s2 = 1, pins;
	logic        pin, i1, i2;
	int          fail_count = 0, cmp_count = 0, n1 = 0, n2 = 0, cyc = 0;
	int          seed = 58403;
	logic [7:0]  exp_q [$];

	tmr_core dut_u (.mclk(mclk), .rst(rst), .count_tick(tick), .reg_addr(addr),
		.reg_wr(wr), .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdat),
		.first_edge_input(pins[0]), .second_edge_input(pins[1]),
		.first_edge_sel(s1), .second_edge_sel(s2), .timer_output_pin(pin),
		.timer_match_interrupt_first(i1), .timer_match_interrupt_second(i2));
	tmr_pins_model pm_u (.mclk(mclk), .rst(rst), .go(go), .pins(pins));

	initial forever #20 mclk = ~mclk; // Never halted for low power.

	// Count interrupt pulses and cycles; reads answer one cycle later.
	always @(posedge mclk) begin
		rd_d <= rd;
		cyc <= cyc + 1;
		if (i1 === 1'b1) n1 <= n1 + 1;
		if (i2 === 1'b1) n2 <= n2 + 1;
	end
	// The oldest note is compared when read data appears.
	always @(negedge mclk) begin
		if (rd_d) chk(rdat, exp_q.pop_front());
		if (cyc > 90000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr8(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		{wr, addr, wd} = {1'b1, a, d};
		@(negedge mclk);
		wr = 0;
	endtask
	task automatic rd8(input logic [15:0] a, input logic [7:0] e);
		@(negedge mclk);
		{rd, addr} = {1'b1, a};
		exp_q.push_back(e);
		@(negedge mclk);
		rd = 0;
	endtask
	task automatic run(input int n);
		@(negedge mclk);
		tick = 1;
		repeat (n) @(negedge mclk);
		tick = 0;
	endtask
	// Pin is registered, so let two edges pass before looking.
	task automatic pchk(input logic e);
		repeat (2) @(negedge mclk);
		chk({7'h00, pin}, {7'h00, e});
	endtask
	// Edge pulse on the chosen pins while ticking; counts first interrupts.
	task automatic pulse(input logic [1:0] g);
		@(negedge mclk);
		{tick, go} = {1'b1, g};
		n1 = 0;
		@(negedge mclk);
		go = 0;
		repeat (12) @(negedge mclk);
		tick = 0;
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		v = (8'($random(seed)) & 8'h0F) + 8'h01;
		repeat (16) @(negedge mclk);
		rst = 0;
		rd8(TMR_ADDR_MODE_CTRL, 8'h00);
		rd8(TMR_ADDR_CAPCMP_CTRL, 8'h00);
		rd8(TMR_ADDR_OUT_CTRL, 8'h00);
		rd8(16'hFF70, 8'h00);
		wr8(TMR_ADDR_MODE_CTRL, 8'h02);
		pulse(2'h3);
		rd8(TMR_ADDR_COUNT_LO, 8'h00);
		chk(8'(n1 + n2), 8'h00);
		wr8(TMR_ADDR_MODE_CTRL, 8'h06);
		run(v);
		rd8(TMR_ADDR_COUNT_LO, v);
		rd8(TMR_ADDR_COUNT_HI, 8'h00);
		wr8(TMR_ADDR_MODE_CTRL, 8'h00);
		rd8(TMR_ADDR_COUNT_LO, 8'h00);
		wr8(TMR_ADDR_FIRST_LO, v);
		wr8(TMR_ADDR_OUT_CTRL, 8'h03);
		wr8(TMR_ADDR_MODE_CTRL, 8'h0C);
		n1 = 0;
		n2 = 0;
		run(v + 1);
		@(negedge mclk);
		chk(8'(n1), 8'h01);
		chk(8'(n2), 8'h01);
		pchk(1'b1);
		wr8(TMR_ADDR_MODE_CTRL, 8'h00);
		rd8(TMR_ADDR_COUNT_LO, 8'h00);
		pchk(1'b1);
		wr8(TMR_ADDR_OUT_CTRL, 8'h02);
		pchk(1'b0);
		wr8(TMR_ADDR_OUT_CTRL, 8'h65);
		pchk(1'b0);
		wr8(TMR_ADDR_OUT_CTRL, 8'h29);
		pchk(1'b1);
		rd8(TMR_ADDR_OUT_CTRL, 8'h21);
		wr8(TMR_ADDR_FIRST_LO, 8'hFF);
		wr8(TMR_ADDR_FIRST_HI, 8'hFF);
		wr8(TMR_ADDR_MODE_CTRL, 8'h04);
		run(65536);
		rd8(TMR_ADDR_MODE_CTRL, 8'h05);
		wr8(TMR_ADDR_MODE_CTRL, 8'h04);
		rd8(TMR_ADDR_MODE_CTRL, 8'h05);
		run(1);
		wr8(TMR_ADDR_MODE_CTRL, 8'h04);
		rd8(TMR_ADDR_MODE_CTRL, 8'h04);
		wr8(TMR_ADDR_MODE_CTRL, 8'h00);
		wr8(TMR_ADDR_CAPCMP_CTRL, 8'h01);
		wr8(TMR_ADDR_MODE_CTRL, 8'h04);
		pulse(2'h2);
		chk(8'(n1), 8'h01);
		wr8(TMR_ADDR_MODE_CTRL, 8'h00);
		wr8(TMR_ADDR_CAPCMP_CTRL, 8'h03);
		s1 = 2'h3;
		wr8(TMR_ADDR_MODE_CTRL, 8'h04);
		pulse(2'h1);
		chk(8'(n1), 8'h00);
		wr8(TMR_ADDR_MODE_CTRL, 8'h00);
		s1 = 2'h0;
		wr8(TMR_ADDR_MODE_CTRL, 8'h04);
		pulse(2'h1);
		chk(8'(n1), 8'h01);
		wr8(TMR_ADDR_MODE_CTRL, 8'h00);
		wr8(TMR_ADDR_CAPCMP_CTRL, 8'h00);
		wr8(TMR_ADDR_OUT_CTRL, 8'h01);
		wr8(TMR_ADDR_MODE_CTRL, 8'h06);
		pulse(2'h1);
		pchk(1'b0);
		wr8(TMR_ADDR_MODE_CTRL, 8'h00);
		wr8(TMR_ADDR_FIRST_LO, 8'h08);
		wr8(TMR_ADDR_FIRST_HI, 8'h00);
		wr8(TMR_ADDR_SECOND_LO, 8'h04);
		wr8(TMR_ADDR_OUT_CTRL, 8'h21);
		wr8(TMR_ADDR_MODE_CTRL, 8'h0C);
		wr8(TMR_ADDR_OUT_CTRL, 8'h61);
		run(6);
		pchk(1'b0);
		wr8(TMR_ADDR_MODE_CTRL, 8'h00);
		wr8(TMR_ADDR_OUT_CTRL, 8'h21);
		wr8(TMR_ADDR_MODE_CTRL, 8'h04);
		run(6);
		pchk(1'b0);
		wr8(TMR_ADDR_MODE_CTRL, 8'h00);
		wr8(TMR_ADDR_MODE_CTRL, 8'h04);
		wr8(TMR_ADDR_OUT_CTRL, 8'h61);
		run(6);
		pchk(1'b1);
		run(3);
		pchk(1'b0);
		wrap_up();
	end
endmodule
